// ---- hw/sswc_pkg.sv ----
// constants shared by the sleep-state and wake controller
package sswc_pkg;
    localparam int CLK_MHZ        = 125;
    localparam int TICK_US        = 1000;
    localparam int TICK_CYCLES    = CLK_MHZ * TICK_US;
    localparam int SHORT_PRESS_MS = 4000;
    localparam int LONG_PRESS_MS  = 6000;
    localparam int BLINK_MS       = 250;
    localparam int TACH_WINDOW_MS = 1000;
    localparam int FAN_NUM        = 4;
    localparam int INIT_LEDS      = 6;
    localparam int DISK_NUM       = 4;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_LEDS   = 8'h0c;
    localparam logic [7:0] REG_DUTY   = 8'h10;
    localparam logic [7:0] REG_TACH0  = 8'h14;

    localparam int CTRL_LAN  = 0;
    localparam int CTRL_PME  = 1;
    localparam int CTRL_S5   = 2;
    localparam int CTRL_IR45 = 3;
    localparam int CTRL_DUAL = 4;
    localparam logic [4:0]  CTRL_RESET = 5'h13;
    localparam logic [31:0] DUTY_RESET = 32'h80808080;

    localparam int ST_WDT   = 3;
    localparam int ST_RECOV = 4;
    localparam int ST_SRC   = 5;

    localparam logic [2:0] CODE_S0 = 3'h0;
    localparam logic [2:0] CODE_S1 = 3'h1;
    localparam logic [2:0] CODE_S3 = 3'h3;
    localparam logic [2:0] CODE_S4 = 3'h4;
    localparam logic [2:0] CODE_S5 = 3'h5;

    localparam int W_LAN  = 0;
    localparam int W_PME  = 1;
    localparam int W_PCIE = 2;
    localparam int W_USB  = 3;
    localparam int W_IR   = 4;
    localparam int W_RTC  = 5;
    localparam int W_BTN  = 6;

    localparam logic [1:0] WDT_OFF   = 2'h0;
    localparam logic [1:0] WDT_FLASH = 2'h1;
    localparam logic [1:0] WDT_ON    = 2'h2;

    localparam logic [1:0] POLICY_OFF  = 2'h0;
    localparam logic [1:0] POLICY_ON   = 2'h1;
    localparam logic [1:0] POLICY_LAST = 2'h2;

    typedef enum logic [2:0] {SSWC_S0, SSWC_S1, SSWC_S3, SSWC_S4, SSWC_S5} sswc_state_type;
endpackage

// ---- hw/sswc_fan.sv ----
// one 4-pin fan channel: pwm drive and tachometer edge count
`timescale 1ns/100ps
`default_nettype none
module sswc_fan
    import sswc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fan_on,
    input  wire logic [7:0]  duty,
    input  wire logic        tach,
    input  wire logic        window,
    output logic             pwm,
    output logic      [15:0] tach_count
);
    typedef struct packed {
        logic [7:0]  phase;
        logic        tach_q;
        logic [15:0] edges;
        logic        pwm;
        logic [15:0] count;
    } sswc_fan_type;

    sswc_fan_type s;
    sswc_fan_type next_s;

    // pwm compares a free phase; edges saturate so a stuck tach never wraps
    always_comb begin
        next_s        = s;
        next_s.phase  = s.phase + 8'h01;
        next_s.pwm    = fan_on && (s.phase < duty);
        next_s.tach_q = tach;
        if (window) begin
            next_s.count = s.edges;
            next_s.edges = 16'h0000;
        end else if (tach && !s.tach_q && s.edges != 16'hffff) begin
            next_s.edges = s.edges + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pwm        = s.pwm;
    assign tach_count = s.count;
endmodule
`default_nettype wire

// ---- hw/sswc_top.sv ----
// sleep-state and wake controller with apb registers, fans and leds
//
// Behaviour
// - usb activity wakes from S1/S3 only
// - pme wakes S1-S4 when its enable set; S5 also needs the S5 option
// - pcie wake wakes any sleeping state
// - infrared wakes S3; S4/S5 by option
// - S5 network and pme wake off by default
// - S5 network wake when option enabled
// - network wake output powers system up
// - wake from S3 returns to working
// - S3 power led amber or off
// - power-off command removes all non-standby rails
// - restore previous on/off after ac loss
// - ac loss behaviour chosen by stored option
// - fans run in S0 and S1
// - fans off when off or S3-S5
// - pwm drive and tach read per fan
// - watchdog reset shown on watchdog led
// - recovery button makes watchdog led steady unless wdt_mode is off
// - init leds flash then stay on
// - os led steady on by firmware
// - standby led lit while standby power
// - disk led follows any drive activity
// - short press toggles, long press forces off
`timescale 1ns/100ps
`default_nettype none
module sswc_top
    import sswc_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 pwr_btn,
    input  wire logic                 lan_wake_n,
    input  wire logic                 pci_pme_n,
    input  wire logic                 pcie_wake_n,
    input  wire logic                 usb_activity,
    input  wire logic                 infrared_remote_activity,
    input  wire logic                 rtc_alarm,
    input  wire logic                 watchdog_reset,
    input  wire logic                 recovery_button,
    input  wire logic [DISK_NUM-1:0]  disk_activity,
    input  wire logic [1:0]           nv_policy,
    input  wire logic                 nv_was_on,
    output logic                      nv_on_save,
    output logic                      ps_on_n,
    output logic                      fan_enable,
    output logic      [FAN_NUM-1:0]   fan_pwm,
    input  wire logic [FAN_NUM-1:0]   fan_tach,
    output logic                      led_power_green,
    output logic                      led_power_amber,
    output logic                      led_standby,
    output logic                      led_disk,
    output logic                      led_watchdog,
    output logic      [INIT_LEDS-1:0] led_init,
    output logic                      led_os
);
    typedef struct packed {
        sswc_state_type        state;
        logic                  booted;
        logic [4:0]            ctrl;
        logic                  wdt_fired;
        logic                  recov_seen;
        logic [6:0]            wake_src;
        logic [1:0]            wdt_mode;
        logic [INIT_LEDS-1:0]  init_start;
        logic [INIT_LEDS-1:0]  init_done;
        logic                  os_on;
        logic [31:0]           duty;
        logic [31:0]           tick_cnt;
        logic [7:0]            blink_ms;
        logic                  blink;
        logic [9:0]            sec_ms;
        logic                  window;
        logic [12:0]           press_ms;
        logic                  btn_q;
        logic                  forced;
        logic                  pready;
        logic [31:0]           prdata;
        logic                  pslverr;
        logic                  ps_on_n;
        logic                  fan_en;
        logic                  green;
        logic                  amber;
        logic                  standby;
        logic                  disk;
        logic                  wdt_led;
        logic [INIT_LEDS-1:0]  init_led;
        logic                  os_led;
        logic                  nv_on;
    } sswc_regs_type;

    sswc_regs_type s;
    sswc_regs_type next_s;

    logic [5:0]   hit;
    logic [15:0]  tach_count [FAN_NUM];

    function automatic logic [2:0] state_code(input sswc_state_type st);
        case (st)
            SSWC_S0: state_code = CODE_S0;
            SSWC_S1: state_code = CODE_S1;
            SSWC_S3: state_code = CODE_S3;
            SSWC_S4: state_code = CODE_S4;
            default: state_code = CODE_S5;
        endcase
    endfunction

    // qualify each wake source against the current state and its enables
    always_comb begin
        logic sleeping;
        logic light;
        logic deep;
        sleeping = s.booted && (s.state != SSWC_S0);
        light    = s.booted && (s.state == SSWC_S1 || s.state == SSWC_S3);
        deep     = s.booted && (s.state == SSWC_S4);
        hit[W_LAN]  = !lan_wake_n && s.ctrl[CTRL_LAN]
                      && (light || deep || (s.state == SSWC_S5 && s.ctrl[CTRL_S5]));
        hit[W_PME]  = !pci_pme_n && s.ctrl[CTRL_PME]
                      && (light || deep || (s.state == SSWC_S5 && s.ctrl[CTRL_S5]));
        hit[W_PCIE] = !pcie_wake_n && sleeping;
        hit[W_USB]  = usb_activity && light;
        hit[W_IR]   = infrared_remote_activity && (light || (sleeping && s.ctrl[CTRL_IR45]));
        hit[W_RTC]  = rtc_alarm && sleeping;
    end

    // one pass computes every register from the current state and inputs
    always_comb begin
        logic wr;
        logic tick;
        logic release_short;
        logic on_next;
        next_s  = s;
        wr      = psel && penable && pwrite && s.pready;
        tick    = (s.tick_cnt == 32'(TICK_CYC - 1));
        next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;

        // slow rates all derive from the millisecond tick
        next_s.window = 1'b0;
        if (tick) begin
            next_s.blink_ms = (s.blink_ms == 8'(BLINK_MS - 1)) ? 8'h00 : s.blink_ms + 8'h01;
            if (s.blink_ms == 8'(BLINK_MS - 1)) begin
                next_s.blink = !s.blink;
            end
            next_s.sec_ms = (s.sec_ms == 10'(TACH_WINDOW_MS - 1)) ? 10'h000 : s.sec_ms + 10'h001;
            next_s.window = (s.sec_ms == 10'(TACH_WINDOW_MS - 1));
        end

        // apb: answer is prepared in setup and shown in the access phase
        next_s.pready  = psel && !penable;
        next_s.pslverr = 1'b0;
        next_s.prdata  = 32'h0;
        if (psel && !penable) begin
            case (paddr)
                REG_CTRL:   next_s.prdata = {27'h0, s.ctrl};
                REG_CMD:    next_s.prdata = {29'h0, state_code(s.state)};
                REG_STATUS: next_s.prdata = {20'h0, s.wake_src, s.recov_seen, s.wdt_fired,
                                             state_code(s.state)};
                REG_LEDS:   next_s.prdata = {17'h0, s.os_on, s.init_done, s.init_start, s.wdt_mode};
                REG_DUTY:   next_s.prdata = s.duty;
                default: begin
                    next_s.pslverr = 1'b1;
                    for (int i = 0; i < FAN_NUM; i++) begin
                        if (paddr == REG_TACH0 + 8'(4 * i)) begin
                            next_s.prdata  = {16'h0, tach_count[i]};
                            next_s.pslverr = 1'b0;
                        end
                    end
                end
            endcase
        end
        if (wr) begin
            case (paddr)
                REG_CTRL: next_s.ctrl = pwdata[4:0];
                REG_LEDS: begin
                    next_s.wdt_mode   = pwdata[1:0];
                    next_s.init_start = pwdata[7:2];
                    next_s.init_done  = pwdata[13:8];
                    next_s.os_on      = pwdata[14];
                end
                REG_DUTY: next_s.duty = pwdata;
                default: ;
            endcase
        end

        // sticky watchdog flag, set wins over clear
        next_s.wdt_fired  = (s.wdt_fired && !(wr && paddr == REG_STATUS && pwdata[ST_WDT]))
                            || watchdog_reset;
        next_s.recov_seen = (s.recov_seen && !(wr && paddr == REG_STATUS && pwdata[ST_RECOV]))
                            || recovery_button;

        next_s.btn_q  = pwr_btn;
        release_short = s.btn_q && !pwr_btn && !s.forced
                        && (s.press_ms < 13'(SHORT_PRESS_MS));
        if (!pwr_btn) begin
            next_s.press_ms = 13'h0000;
            next_s.forced   = 1'b0;
        end else if (tick && s.press_ms != 13'h1fff) begin
            next_s.press_ms = s.press_ms + 13'h0001;
        end

        // first cycle after reset applies the stored policy
        if (!s.booted) begin
            next_s.booted = 1'b1;
            next_s.state  = (nv_policy == POLICY_ON || (nv_policy == POLICY_LAST && nv_was_on))
                            ? SSWC_S0 : SSWC_S5;
        end else if (pwr_btn && !s.forced && s.press_ms >= 13'(LONG_PRESS_MS)) begin
            next_s.state  = SSWC_S5;
            next_s.forced = 1'b1;
        end else if (release_short) begin
            if (s.state == SSWC_S0) begin
                next_s.state = SSWC_S3;
            end else begin
                next_s.state    = SSWC_S0;
                next_s.wake_src = 7'h01 << W_BTN;
            end
        end else if (|hit) begin
            next_s.state    = SSWC_S0;
            next_s.wake_src = {1'b0, hit};
        end else if (wr && paddr == REG_CMD && s.state == SSWC_S0) begin
            case (pwdata[2:0])
                CODE_S1: next_s.state = SSWC_S1;
                CODE_S3: next_s.state = SSWC_S3;
                CODE_S4: next_s.state = SSWC_S4;
                CODE_S5: next_s.state = SSWC_S5;
                default: ;
            endcase
        end

        // outputs follow the next state so pins match the state register
        on_next = next_s.booted && (next_s.state == SSWC_S0 || next_s.state == SSWC_S1);
        // rails only while working or S1
        next_s.ps_on_n = !on_next;
        next_s.fan_en  = on_next;
        next_s.nv_on   = on_next;
        // S3 shows amber on dual leds only
        next_s.green   = on_next;
        next_s.amber   = next_s.state == SSWC_S3 && next_s.ctrl[CTRL_DUAL];
        // standby power means this logic runs
        next_s.standby = 1'b1;
        // any drive lights the disk led
        next_s.disk    = |disk_activity;
        if (next_s.recov_seen && next_s.wdt_mode != WDT_OFF) begin
            next_s.wdt_led = 1'b1;
        end else if (next_s.wdt_fired || next_s.wdt_mode == WDT_FLASH) begin
            next_s.wdt_led = next_s.blink;
        end else begin
            next_s.wdt_led = next_s.wdt_mode == WDT_ON;
        end
        // flash while started, steady once done
        next_s.init_led = next_s.init_done | (next_s.init_start & {INIT_LEDS{next_s.blink}});
        next_s.os_led   = next_s.os_on;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.state    <= SSWC_S5;
            s.ctrl     <= CTRL_RESET;
            s.duty     <= DUTY_RESET;
            s.ps_on_n  <= 1'b1;
            s.standby  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // one pwm and tach channel per fan header
    for (genvar g = 0; g < FAN_NUM; g++) begin : g_fan
        sswc_fan u_fan (
            .pclk       (pclk),
            .presetn    (presetn),
            .fan_on     (s.fan_en),
            .duty       (s.duty[8*g +: 8]),
            .tach       (fan_tach[g]),
            .window     (s.window),
            .pwm        (fan_pwm[g]),
            .tach_count (tach_count[g])
        );
    end

    assign prdata          = s.prdata;
    assign pready          = s.pready;
    assign pslverr         = s.pslverr;
    assign ps_on_n         = s.ps_on_n;
    assign fan_enable      = s.fan_en;
    assign led_power_green = s.green;
    assign led_power_amber = s.amber;
    assign led_standby     = s.standby;
    assign led_disk        = s.disk;
    assign led_watchdog    = s.wdt_led;
    assign led_init        = s.init_led;
    assign led_os          = s.os_led;
    assign nv_on_save      = s.nv_on;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cmd_off;
        psel && penable && pwrite && pready && paddr == REG_CMD && pwdata[2:0] == CODE_S5;
    endsequence
    sequence s_quiet_s0;
        s.booted && s.state == SSWC_S0 && !pwr_btn && !s.btn_q;
    endsequence

    property p_usb_wake;
        s.state == SSWC_S3 && usb_activity && s.booted && !pwr_btn && !s.btn_q |=> s.state == SSWC_S0;
    endproperty
    a_usb_wake: assert property (p_usb_wake) else $error("usb did not wake from S3");

    property p_usb_deep;
        s.state == SSWC_S4 || s.state == SSWC_S5 |-> !hit[W_USB];
    endproperty
    a_usb_deep: assert property (p_usb_deep) else $error("usb wake in deep sleep");

    property p_pme_gate;
        !s.ctrl[CTRL_PME] |-> !hit[W_PME];
    endproperty
    a_pme_gate: assert property (p_pme_gate) else $error("pme wake while disabled");

    property p_pcie;
        s.booted && s.state != SSWC_S0 && !pcie_wake_n && !pwr_btn && !s.btn_q |=> s.state == SSWC_S0 && !ps_on_n;
    endproperty
    a_pcie: assert property (p_pcie) else $error("pcie wake missed");

    property p_s5_gate;
        s.state == SSWC_S5 && !s.ctrl[CTRL_S5] |-> !hit[W_LAN] && !hit[W_PME];
    endproperty
    a_s5_gate: assert property (p_s5_gate) else $error("S5 network wake while off");

    property p_awake;
        s.state == SSWC_S0 |-> hit == 6'h00;
    endproperty
    a_awake: assert property (p_awake) else $error("wake seen while working");

    property p_off_cmd;
        s_cmd_off ##0 s_quiet_s0 |=> ps_on_n && !fan_enable && s.state == SSWC_S5;
    endproperty
    a_off_cmd: assert property (p_off_cmd) else $error("power-off command ignored");

    property p_fans;
        fan_enable == (s.booted && (s.state == SSWC_S0 || s.state == SSWC_S1));
    endproperty
    a_fans: assert property (p_fans) else $error("fan state wrong");

    property p_s3_led;
        s.state == SSWC_S3 |-> !led_power_green && (led_power_amber == s.ctrl[CTRL_DUAL]);
    endproperty
    a_s3_led: assert property (p_s3_led) else $error("S3 power led wrong");

    property p_long;
        s.booted && pwr_btn && !s.forced && s.press_ms >= 13'(LONG_PRESS_MS) |=> s.state == SSWC_S5 && s.forced;
    endproperty
    a_long: assert property (p_long) else $error("long press did not force off");

    property p_standby;
        led_standby;
    endproperty
    a_standby: assert property (p_standby) else $error("standby led dark");
endmodule
`default_nettype wire

// ---- tb/sswc_wake_model.sv ----
// wake-source and fan tachometer model on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
module sswc_wake_model (
    input  wire logic       pclk,
    input  wire logic [5:0] wake_req,
    output logic            lan_wake_n,
    output logic            pci_pme_n,
    output logic            pcie_wake_n,
    output logic            usb_activity,
    output logic            infrared_remote_activity,
    output logic            rtc_alarm,
    output logic      [3:0] fan_tach
);
    int half [4] = '{25, 50, 75, 100};
    int tcnt [4] = '{0, 0, 0, 0};

    // released lines rest at their pull level, never at the last driven value
    initial begin
        {lan_wake_n, pci_pme_n, pcie_wake_n} = 3'b111;
        {usb_activity, infrared_remote_activity, rtc_alarm} = 3'b000;
        fan_tach = 4'h0;
    end

    always @(posedge pclk) begin
        lan_wake_n               <= !wake_req[0];
        pci_pme_n                <= !wake_req[1];
        pcie_wake_n              <= !wake_req[2];
        usb_activity             <= wake_req[3];
        infrared_remote_activity <= wake_req[4];
        rtc_alarm                <= wake_req[5];
    end

    // each fan turns at its own rate, so a swapped channel shows up
    always @(posedge pclk) begin
        for (int f = 0; f < 4; f++) begin
            tcnt[f] <= (tcnt[f] == half[f] - 1) ? 0 : tcnt[f] + 1;
            if (tcnt[f] == half[f] - 1) begin
                fan_tach[f] <= !fan_tach[f];
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/sswc_top_tb.sv ----
// self-checking bench for the sleep-state and wake controller
`timescale 1ns/100ps
`default_nettype none
module sswc_top_tb
    import sswc_pkg::*;
;
    localparam int TICK  = 5;
    localparam int BLINK = BLINK_MS * TICK;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, ps_on_n, nv_on_save, fan_enable, nv_was_on = 1'b0;
    logic        pwr_btn = 1'b0, watchdog_reset = 1'b0, recovery_button = 1'b0;
    logic [1:0]  nv_policy = POLICY_OFF;
    logic [3:0]  disk_activity = 4'h0, fan_pwm, fan_tach;
    logic [5:0]  wake_req = 6'h0, led_init;
    logic        lan_n, pme_n, pcie_n, usb, ir, rtc, s_wd;
    logic        led_green, led_amber, led_standby, led_disk, led_watchdog, led_os;
    logic [6:0]  s0;
    logic [15:0] c;
    // ctrl byte, target state code, source index, 1 if the source must wake
    logic [15:0] cases [19] = '{16'h1706, 16'h1717, 16'h1713, 16'h1715, 16'h171b, 16'h1719,
                                16'h1739, 16'h1737, 16'h1731, 16'h1532, 16'h1746, 16'h1748,
                                16'h1f49, 16'h1745, 16'h1756, 16'h175b, 16'h1751, 16'h1350, 16'h1352};
    int          n_mismatch = 0, num_checks = 0, cyc = 0, cnt [4], e;

    sswc_top #(.TICK_CYC(TICK)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwr_btn(pwr_btn), .lan_wake_n(lan_n), .pci_pme_n(pme_n), .pcie_wake_n(pcie_n),
        .usb_activity(usb), .infrared_remote_activity(ir), .rtc_alarm(rtc),
        .watchdog_reset(watchdog_reset), .recovery_button(recovery_button),
        .disk_activity(disk_activity), .nv_policy(nv_policy), .nv_was_on(nv_was_on),
        .nv_on_save(nv_on_save), .ps_on_n(ps_on_n), .fan_enable(fan_enable), .fan_pwm(fan_pwm),
        .fan_tach(fan_tach), .led_power_green(led_green), .led_power_amber(led_amber),
        .led_standby(led_standby), .led_disk(led_disk), .led_watchdog(led_watchdog),
        .led_init(led_init), .led_os(led_os));

    sswc_wake_model model (
        .pclk(pclk), .wake_req(wake_req), .lan_wake_n(lan_n), .pci_pme_n(pme_n),
        .pcie_wake_n(pcie_n), .usb_activity(usb), .infrared_remote_activity(ir),
        .rtc_alarm(rtc), .fan_tach(fan_tach));

    // free-running 125 MHz clock
    initial begin
        forever #4 pclk = ~pclk;
    end

    // hang guard: the sequence needs just under half of this
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] g, input logic [32:0] x, input string m);
        num_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, m, g, x);
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, 1, "pready wait");
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int s);
        wake_req[s] <= 1'b1;
        repeat (3) @(posedge pclk);
        wake_req <= 6'h0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task automatic press(input int n);
        pwr_btn <= 1'b1;
        repeat (n) @(posedge pclk);
        pwr_btn <= 1'b0;
        repeat (5) @(posedge pclk);
        rd(REG_CMD);
    endtask

    initial begin
        do_reset();
        chk(led_standby, 1, "standby led");
        chk(ps_on_n, 1, "rails after reset");
        rd(REG_CTRL);
        chk(rdat, 32'h13, "ctrl default");
        rd(REG_DUTY);
        chk(rdat, 32'h80808080, "duty default");
        rd(8'h40);
        chk({rerr, rdat}, 33'h100000000, "unmapped read");
        pulse(W_PCIE);
        rd(REG_CMD);
        chk(rdat[2:0], 0, "pcie wake from S5");
        // each case but the first sleeps through a command, then offers one wake source
        foreach (cases[i]) begin
            c = cases[i];
            wr(REG_CTRL, {24'h0, c[15:8]});
            wr(REG_CMD, {28'h0, c[7:4]});
            repeat (2) @(posedge pclk);
            chk(fan_enable, c[7:4] < 2, "fan gate");
            chk(led_amber, c[7:4] == 3, "amber led");
            chk(led_green, c[7:4] < 2, "green led");
            chk(ps_on_n, c[7:4] > 1, "main rails");
            pulse(c[3:1]);
            rd(REG_CMD);
            chk(rdat[2:0], c[0] ? 3'h0 : c[6:4], "state after wake");
            if (rdat[2:0] !== 3'h0) begin
                pulse(W_PCIE);
            end
        end
        // duty cycle counted over one whole pwm period
        wr(REG_DUTY, 32'hff400100);
        cnt = '{0, 0, 0, 0};
        repeat (256) begin
            @(posedge pclk);
            for (int f = 0; f < 4; f++) cnt[f] += fan_pwm[f];
        end
        for (int f = 0; f < 4; f++) chk(cnt[f], (32'hff400100 >> (8 * f)) & 32'hff, "pwm");
        repeat (10500) @(posedge pclk);
        for (int f = 0; f < 4; f++) begin
            e = 100 / (f + 1);
            rd(REG_TACH0 + 8'(4 * f));
            chk(rdat + 1 >= e && rdat <= e + 1, 1, "tach count");
        end
        // indicators: watchdog flash, init start/done, os steady
        watchdog_reset <= 1'b1;
        @(posedge pclk);
        watchdog_reset <= 1'b0;
        rd(REG_STATUS);
        chk(rdat[ST_WDT], 1, "watchdog flag");
        wr(REG_LEDS, 32'h4205);
        s0 = {led_watchdog, led_init};
        repeat (BLINK) @(posedge pclk);
        chk(s0 ^ {led_watchdog, led_init}, 7'h41, "blinking leds");
        chk(led_init & 6'h3e, 6'h02, "init done steady");
        chk(led_os, 1, "os led");
        recovery_button <= 1'b1;
        @(posedge pclk);
        recovery_button <= 1'b0;
        repeat (3) @(posedge pclk);
        s_wd = led_watchdog;
        repeat (BLINK) @(posedge pclk);
        chk({s_wd, led_watchdog}, 2'b11, "recovery steady");
        wr(REG_STATUS, 32'h18);
        rd(REG_STATUS);
        chk(rdat[4:3], 0, "flags cleared");
        for (int d = 0; d < 4; d++) begin
            disk_activity <= 4'h1 << d;
            repeat (3) @(posedge pclk);
            chk(led_disk, 1, "disk led on");
            disk_activity <= 4'h0;
            repeat (3) @(posedge pclk);
            chk(led_disk, 0, "disk led off");
        end
        // power switch: short toggles, long forces off once per press
        press(100);
        chk(rdat[2:0], 3, "short press sleeps");
        press(100);
        chk(rdat[2:0], 0, "short press wakes");
        pwr_btn <= 1'b1;
        repeat (LONG_PRESS_MS * TICK - 100) @(posedge pclk);
        chk(ps_on_n, 0, "not off before long limit");
        repeat (300) @(posedge pclk);
        chk(ps_on_n, 1, "long press off");
        press(1);
        chk(rdat[2:0], 5, "release after long press");
        // ac restore under each stored policy
        for (int k = 0; k < 4; k++) begin
            nv_policy <= (k == 0) ? POLICY_OFF : (k == 1) ? POLICY_ON : POLICY_LAST;
            nv_was_on <= (k != 1 && k != 3);
            do_reset();
            chk(ps_on_n, k == 0 || k == 3, "ac restore");
            chk(nv_on_save, k == 1 || k == 2, "saved on state");
        end
        wrap_up();
    end
endmodule
`default_nettype wire
